// File: include/cpt_pkg.sv
// Package with register map, field positions and timing constants.
package cpt_pkg;
  localparam logic [7:0] OFF_DRIVE   = 8'h56;
  localparam logic [7:0] OFF_CLKCTL  = 8'h58;
  localparam logic [7:0] OFF_COUNT   = 8'h59;
  localparam logic [7:0] OFF_PRELOAD = 8'h5b;
  localparam logic [7:0] RST_DRIVE   = 8'h00;
  localparam logic [7:0] RST_CLKCTL  = 8'h10;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_PRELOAD = 8'h00;
  localparam int DRV_FORCE_BIT  = 0;
  localparam int DRV_DUTY_LSB   = 1;
  localparam int DRV_CLKSEL_BIT = 7;
  localparam int CTL_SRC_BIT    = 0;
  localparam int CTL_MULT_BIT   = 2;
  localparam int CTL_DIV_LSB    = 4;
  localparam logic [7:0] CTL_WMASK = 8'h35;
  localparam logic [7:0] CNT_MAX   = 8'hff;
  // Base-period lengths in clk cycles, indexed by {clksel, src}.
  // Clock runs at 10 MHz (100 ns period).
  localparam int CLK_PERIOD_NS = 100;
  localparam int BASE_NS_0 = 3200;
  localparam int BASE_NS_1 = 1600;
  localparam int BASE_NS_2 = 800;
  localparam int BASE_NS_3 = 400;
  localparam logic [7:0] BASE_CYC_0 = 8'((BASE_NS_0) / CLK_PERIOD_NS);
  localparam logic [7:0] BASE_CYC_1 = 8'((BASE_NS_1) / CLK_PERIOD_NS);
  localparam logic [7:0] BASE_CYC_2 = 8'((BASE_NS_2) / CLK_PERIOD_NS);
  localparam logic [7:0] BASE_CYC_3 = 8'((BASE_NS_3) / CLK_PERIOD_NS);
  typedef struct packed {
    logic       force_hi;
    logic [5:0] duty;
    logic [1:0] clk_sel;
    logic       dbl;
  } cpt_pwm_cfg_s;
endpackage

// File: rtl/cpt_tach.sv
`timescale 1ns/1ns
// Tachometer: counts scaled clock cycles per fan pulse and latches result.
module cpt_tach (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tach_in,
  input  wire logic [1:0] div_sel,
  input  wire logic [7:0] preload,
  input  wire logic       restart,
  output logic [7:0]      count_q
);
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [6:0] pre_q;
  logic       tach_q;
  logic       arm_q;
  wire        rise_w = tach_in & ~tach_q;
  wire  [6:0] pre_lim_w = 7'((8'h1 << div_sel) - 8'h1);
  wire        tick_w = (pre_q >= pre_lim_w);
  wire        sat_w  = (run_q == cpt_pkg::CNT_MAX);

  // Prescaler gives one counting enable every 1, 2, 4 or 8 cycles. [R5]
  always_ff @(posedge clk) begin
    if (!rst_n || restart || rise_w || tick_w) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // Counting saturates, so a pulse too long for 8 bits reads full scale. [R12]
  assign run_d = (tick_w && !sat_w) ? run_q + 8'h01 : run_q; // [R6]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q   <= cpt_pkg::RST_COUNT;
      tach_q  <= 1'b0;
      arm_q   <= 1'b0;
      count_q <= cpt_pkg::RST_COUNT;
    end else begin
      tach_q <= tach_in;
      if (restart) begin
        run_q <= preload; // [R9] [R10]
        arm_q <= 1'b0;
      end else if (rise_w) begin
        // The first edge after a restart only opens a window. [R7]
        if (arm_q) begin
          count_q <= run_d;
        end
        run_q <= preload; // [R9]
        arm_q <= 1'b1;
      end else begin
        run_q <= run_d;
      end
    end
  end

  property p_sat;
    @(posedge clk) disable iff (!rst_n)
      (sat_w && !restart && !rise_w) |=> sat_w;
  endproperty
  a_sat: assert property (p_sat) else $error("tach count wrapped"); // [R12]

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      restart |=> (run_q == $past(preload)) && !arm_q;
  endproperty
  a_restart: assert property (p_restart) // [R10]
    else $error("restart did not reload");

  property p_latch;
    @(posedge clk) disable iff (!rst_n)
      (rise_w && arm_q && !restart) |=> count_q == $past(run_d);
  endproperty
  a_latch: assert property (p_latch) else $error("count not latched"); // [R7]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !(rise_w && arm_q) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved mid pulse"); // [R6]
endmodule

// File: rtl/cpt_cooler.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
// Cooling fan PWM drive and tachometer with plain register port.
//
// Contract
// R1: A set force bit holds the output high, else the duty field rules.
// R2: Output is high for N of every 64 base periods, N the duty value.
// R3: Base frequency comes from clock select, source select and doubler.
// R4: The doubler bit halves the base period, doubling output frequency.
// R5: Tach counting clock is divided by 1, 2, 4 or 8, default 2.
// R6: Each tach pulse is measured in scaled cycles into an 8-bit register.
// R7: The register shows the final count of the previous pulse only.
// R8: Software treats the count as invalid for two pulses after preload.
// R9: Each count starts from the software preload value.
// R10: A preload write restarts the counting sequence at once.
// R11: Base frequencies come from a constant table indexed by select bits.
// R12: The tach counter saturates at 255 instead of wrapping.
module cpt_cooler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic       tach_in,
  output logic            pwm_out
);
  logic [7:0] drive_q;
  logic [7:0] ctl_q;
  logic [7:0] preload_q;
  logic [7:0] count_w;
  logic [7:0] rdata_d;
  logic [7:0] base_cnt_q;
  logic [5:0] slot_q;
  logic       pwm_q;
  cpt_pkg::cpt_pwm_cfg_s cfg_w;

  wire sel_drive   = (addr == cpt_pkg::OFF_DRIVE);
  wire sel_ctl     = (addr == cpt_pkg::OFF_CLKCTL);
  wire sel_count   = (addr == cpt_pkg::OFF_COUNT);
  wire sel_preload = (addr == cpt_pkg::OFF_PRELOAD);
  wire wr_preload  = wr && sel_preload;

  assign cfg_w.force_hi = drive_q[cpt_pkg::DRV_FORCE_BIT];
  assign cfg_w.duty     = drive_q[cpt_pkg::DRV_DUTY_LSB +: 6];
  assign cfg_w.clk_sel  = {drive_q[cpt_pkg::DRV_CLKSEL_BIT],
                           ctl_q[cpt_pkg::CTL_SRC_BIT]}; // [R3]
  assign cfg_w.dbl      = ctl_q[cpt_pkg::CTL_MULT_BIT];

  // Register writes; reserved control bits are not stored and read zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_q   <= cpt_pkg::RST_DRIVE;
      ctl_q     <= cpt_pkg::RST_CLKCTL; // [R5]
      preload_q <= cpt_pkg::RST_PRELOAD;
    end else if (wr) begin
      if (sel_drive) begin
        drive_q <= wdata;
      end
      if (sel_ctl) begin
        ctl_q <= wdata & cpt_pkg::CTL_WMASK;
      end
      if (sel_preload) begin
        preload_q <= wdata; // [R9]
      end
    end
  end

  // Unmapped addresses read zero; the count register ignores writes.
  assign rdata_d = sel_drive   ? drive_q :
                   sel_ctl     ? ctl_q :
                   sel_count   ? count_w :
                   sel_preload ? preload_q : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Base-period table; the doubler halves the chosen period. [R11] [R4]
  logic [7:0] base_len_w;
  logic [7:0] base_eff_w;
  always_comb begin
    case (cfg_w.clk_sel)
      2'b00: base_len_w = cpt_pkg::BASE_CYC_0;
      2'b01: base_len_w = cpt_pkg::BASE_CYC_1;
      2'b10: base_len_w = cpt_pkg::BASE_CYC_2;
      default: base_len_w = cpt_pkg::BASE_CYC_3;
    endcase
  end
  assign base_eff_w = cfg_w.dbl ? (base_len_w >> 1) : base_len_w; // [R4]
  wire base_tick_w = (base_cnt_q >= base_eff_w - 8'h01);

  always_ff @(posedge clk) begin
    if (!rst_n || base_tick_w) begin
      base_cnt_q <= 8'h00;
    end else begin
      base_cnt_q <= base_cnt_q + 8'h01;
    end
  end

  // A 64-slot frame; slot index below duty means high. [R2]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_q <= 6'h00;
    end else if (base_tick_w) begin
      slot_q <= slot_q + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= cfg_w.force_hi | (slot_q < cfg_w.duty); // [R1] [R2]
    end
  end
  assign pwm_out = pwm_q;

  cpt_tach u_tach (
    .clk     (clk),
    .rst_n   (rst_n),
    .tach_in (tach_in),
    .div_sel (ctl_q[cpt_pkg::CTL_DIV_LSB +: 2]),
    .preload (preload_q),
    .restart (wr_preload), // [R10]
    .count_q (count_w)
  );

  // Checker helpers: cycles since the last base tick, and whether the
  // frequency selection stayed put over that span. A write to either
  // select register voids one span, since the new length is only known
  // after the counter has restarted.
  logic [7:0] gap_q;
  logic       gap_ok_q;
  wire        sel_chg_w = wr && (sel_drive || sel_ctl);
  wire        sel_any_w = sel_drive || sel_ctl || sel_count || sel_preload;

  // Base length worked out straight from the constant table. [R11]
  wire  [7:0] exp_len_w =
    (cfg_w.clk_sel == 2'b00) ? (cpt_pkg::BASE_CYC_0 >> cfg_w.dbl) :
    (cfg_w.clk_sel == 2'b01) ? (cpt_pkg::BASE_CYC_1 >> cfg_w.dbl) :
    (cfg_w.clk_sel == 2'b10) ? (cpt_pkg::BASE_CYC_2 >> cfg_w.dbl) :
                               (cpt_pkg::BASE_CYC_3 >> cfg_w.dbl);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_q    <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (base_tick_w) begin
      gap_q    <= 8'h00;
      gap_ok_q <= !sel_chg_w;
    end else begin
      gap_q <= gap_q + 8'h01;
      if (sel_chg_w) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  property p_force;
    @(posedge clk) disable iff (!rst_n)
      cfg_w.force_hi |=> pwm_out;
  endproperty
  a_force: assert property (p_force) else $error("force not high"); // [R1]

  property p_zero;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_w.force_hi && cfg_w.duty == 6'h00) |=> !pwm_out;
  endproperty
  a_zero: assert property (p_zero) else $error("zero duty not low"); // [R2]

  property p_duty;
    @(posedge clk) disable iff (!rst_n)
      !cfg_w.force_hi |=> pwm_out == ($past(slot_q) < $past(cfg_w.duty));
  endproperty
  a_duty: assert property (p_duty) else $error("duty compare wrong"); // [R2]

  property p_period;
    @(posedge clk) disable iff (!rst_n)
      base_tick_w |=> base_cnt_q == 8'h00;
  endproperty
  a_period: assert property (p_period) else $error("base not restarted"); // [R3]

  property p_dbl;
    @(posedge clk) disable iff (!rst_n)
      cfg_w.dbl |-> base_eff_w == exp_len_w;
  endproperty
  a_dbl: assert property (p_dbl) else $error("doubler wrong"); // [R4]

  property p_rd;
    @(posedge clk) disable iff (!rst_n)
      (rd && sel_drive) |=> rdata == $past(drive_q);
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong"); // [R1]

  property p_preload;
    @(posedge clk) disable iff (!rst_n)
      wr_preload |=> preload_q == $past(wdata);
  endproperty
  a_preload: assert property (p_preload) else $error("preload lost"); // [R9]

  property p_divrst;
    @(posedge clk) !rst_n |=> ctl_q == cpt_pkg::RST_CLKCTL;
  endproperty
  a_divrst: assert property (p_divrst) else $error("divisor reset bad"); // [R5]

  // The selection table is checked apart from the datapath mux, so a
  // swapped select bit shows up as a wrong length, not a silent match.
  property p_nodbl;
    @(posedge clk) disable iff (!rst_n)
      !cfg_w.dbl |-> base_eff_w == exp_len_w;
  endproperty
  a_nodbl: assert property (p_nodbl) // [R4]
    else $error("undoubled base wrong");

  property p_gap;
    @(posedge clk) disable iff (!rst_n)
      (base_tick_w && gap_ok_q) |-> gap_q == exp_len_w - 8'h01;
  endproperty
  a_gap: assert property (p_gap) // [R3]
    else $error("base period length wrong");

  property p_cnt_bound;
    @(posedge clk) disable iff (!rst_n)
      base_cnt_q < cpt_pkg::BASE_CYC_0;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) // [R11]
    else $error("base counter overran");

  // A frame is 64 slots; the slot index wraps with no gap.
  sequence s_frame_end;
    base_tick_w && (slot_q == 6'h3f);
  endsequence

  sequence s_frame_start;
    slot_q == 6'h00;
  endsequence

  property p_frame;
    @(posedge clk) disable iff (!rst_n)
      s_frame_end |=> s_frame_start;
  endproperty
  a_frame: assert property (p_frame) // [R2]
    else $error("frame did not wrap");

  property p_slot_hold;
    @(posedge clk) disable iff (!rst_n)
      !base_tick_w |=> $stable(slot_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) // [R2]
    else $error("slot moved between ticks");

  property p_half;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_w.force_hi && cfg_w.duty == 6'h20) |=>
        pwm_out == !$past(slot_q[5]);
  endproperty
  a_half: assert property (p_half) // [R2]
    else $error("midscale not half");

  property p_full;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_w.force_hi && cfg_w.duty == 6'h3f && slot_q == 6'h3f) |=>
        !pwm_out;
  endproperty
  a_full: assert property (p_full) // [R2]
    else $error("full scale lacks low slot");

  property p_lowcut;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_w.force_hi && slot_q >= cfg_w.duty) |=> !pwm_out;
  endproperty
  a_lowcut: assert property (p_lowcut) // [R2]
    else $error("high past duty");

  // Force reaches the pin two edges after the write: one to store the
  // register, one for the output flop that keeps the pin glitch free.
  sequence s_force_wr;
    wr && sel_drive && wdata[cpt_pkg::DRV_FORCE_BIT];
  endsequence

  property p_force_wr;
    @(posedge clk) disable iff (!rst_n)
      s_force_wr |=> ##1 pwm_out;
  endproperty
  a_force_wr: assert property (p_force_wr) // [R1]
    else $error("force write not seen");

  sequence s_wr_drive;
    wr && sel_drive;
  endsequence

  property p_drive_wr;
    @(posedge clk) disable iff (!rst_n)
      s_wr_drive |=> drive_q == $past(wdata);
  endproperty
  a_drive_wr: assert property (p_drive_wr) // [R1]
    else $error("drive write lost");

  // Reserved control bits are dropped on write so they always read zero.
  sequence s_wr_ctl;
    wr && sel_ctl;
  endsequence

  property p_ctl_mask;
    @(posedge clk) disable iff (!rst_n)
      s_wr_ctl |=> ctl_q == ($past(wdata) & cpt_pkg::CTL_WMASK);
  endproperty
  a_ctl_mask: assert property (p_ctl_mask) // [R5]
    else $error("control write wrong");

  // Read data stand for the one cycle after the strobe and are zero else.
  property p_rd_ctl;
    @(posedge clk) disable iff (!rst_n)
      (rd && sel_ctl) |=> rdata == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) // [R5]
    else $error("control read wrong");

  property p_rd_pre;
    @(posedge clk) disable iff (!rst_n)
      (rd && sel_preload) |=> rdata == $past(preload_q);
  endproperty
  a_rd_pre: assert property (p_rd_pre) // [R9]
    else $error("preload read wrong");

  property p_rd_cnt;
    @(posedge clk) disable iff (!rst_n)
      (rd && sel_count) |=> rdata == $past(count_w);
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) // [R6]
    else $error("count read wrong");

  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // [R6]
    else $error("read data without strobe");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_n)
      (rd && !sel_any_w) |=> rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) // [R6]
    else $error("unmapped read not zero");

  property p_rst_vals;
    @(posedge clk)
      !rst_n |=> drive_q == cpt_pkg::RST_DRIVE &&
        preload_q == cpt_pkg::RST_PRELOAD &&
        count_w == cpt_pkg::RST_COUNT && !pwm_out && rdata == 8'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals) // [R9]
    else $error("reset values wrong");
endmodule

// File: verification/cpt_fan.sv
// Fan model driving the tach input with a two-cycle pulse every period.
`timescale 1ns/1ns
module cpt_fan (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] period,
  output logic             tach_in
);
  logic [11:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || cnt_q + 12'h001 >= period)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_q + 12'h001;
  end
  // A stalled fan leaves the line low, as its pull-down would.
  assign tach_in = (period != 12'h000) && (cnt_q < 12'h002);
endmodule

// File: verification/tb.sv
// Testbench for the fan drive and tachometer block.
`timescale 1ns/1ns
module tb;
  logic        clk, rst_n, wr, rd, tach_in, pwm_out, prev;
  logic [7:0]  addr, wdata, rdata, rv, seed, drv, pl;
  logic [5:0]  dty;
  logic [1:0]  d;
  logic [11:0] period;
  int          n_mismatch, total_checks, hi, base, i, p, k, seen;
  logic [7:0]  ra [5] = '{8'h56, 8'h58, 8'h59, 8'h5b, 8'h57};
  logic [7:0]  re [5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
  cpt_cooler i_cpt_cooler (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tach_in(tach_in),
    .pwm_out(pwm_out));
  cpt_fan i_cpt_fan (.clk(clk), .rst_n(rst_n), .period(period),
    .tach_in(tach_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int base_of(input int sel, input int dbl);
    int b;
    b = 32 >> sel;
    return b >> dbl;
  endfunction
  function automatic int tach_exp(input int pv, input int pr, input int dv);
    int e;
    e = pv + (pr >> dv);
    return e > 255 ? 255 : e;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("reg got %h exp %h", g, e));
  endtask
  task automatic chk_int(input int g, input int e);
    total_checks++;
    if (g != e) fail($sformatf("high cycles %0d exp %0d", g, e));
  endtask
  task automatic chk_cnt(input logic [7:0] g, input int e);
    total_checks++;
    if (g !== 8'(e))
      fail($sformatf("count %h exp %0d", g, e));
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pulses(input int n);
    seen = 0;
    prev = 1'b1;
    for (k = 0; k < 5000 && seen < n; k++) begin
      // Sampled mid-cycle so the model's flop output has settled.
      @(negedge clk);
      if (tach_in === 1'b1 && prev === 1'b0) seen++;
      prev = tach_in;
    end
    if (seen < n) begin
      fail("tach pulses missing");
      print_verdict();
    end
  endtask
  initial begin
    rst_n = 1'b0;
    {wr, rd, addr, wdata, period} = '0;
    seed = 8'h45;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd_reg(ra[i]);
      chk(rv, re[i]);
    end
    wr_reg(8'h59, 8'haa);
    rd_reg(8'h59);
    chk(rv, 8'h00);
    wr_reg(8'h58, 8'hff);
    rd_reg(8'h58);
    chk(rv, 8'h35);
    $display("test registers done");
    // Index eight reuses the slowest clock with the force bit set.
    for (i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      dty = i == 0 ? 6'h00 : i == 1 ? 6'h20 : i == 2 ? 6'h3f : seed[5:0];
      drv = {i[2], dty, i == 8};
      wr_reg(8'h56, drv);
      wr_reg(8'h58, {5'h02, i[0], 1'b0, i[1]});
      base = base_of({i[2], i[1]}, i[0]);
      repeat (128 * base) @(posedge clk);
      hi = 0;
      repeat (64 * base) begin
        @(negedge clk);
        if (pwm_out === 1'b1) hi++;
      end
      chk_int(hi, i == 8 ? 64 * base : dty * base);
    end
    $display("test pwm done");
    for (i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      pl = i == 4 ? 8'hf0 : {2'h0, seed[5:0]};
      p = i == 4 ? 300 : 64 + seed[6:0];
      d = i[1:0];
      period <= p[11:0];
      wr_reg(8'h58, {2'h0, d, 4'h0});
      wr_reg(8'h5b, pl);
      pulses(3);
      rd_reg(8'h59);
      chk_cnt(rv, tach_exp(pl, p, d));
    end
    $display("test tach done");
    print_verdict();
  end
endmodule
